// *** verilog/hse_consts.svh ***
// constants for the hall angle and speed estimator
`ifndef HSE_CONSTS_SVH
`define HSE_CONSTS_SVH

// control interval timing
`define HSE_CLK_HZ         100000000
`define HSE_CTRL_US        50
`define HSE_CTRL_CYC       ((`HSE_CLK_HZ / 1000000) * `HSE_CTRL_US)
`define HSE_CARRIER_HZ     (1000000 / `HSE_CTRL_US)

// angle scale: one electrical turn is 2**16 counts
`define HSE_TURN           17'h10000
`define HSE_HALF_SECTOR    18'h01555
`define HSE_SECTORS        6

// hall input weights
`define HSE_W_WEIGHT       3'h1
`define HSE_V_WEIGHT       3'h2
`define HSE_U_WEIGHT       3'h4

// reference angles per sector
`define HSE_REF0           16'h0000
`define HSE_REF1           16'h2AAB
`define HSE_REF2           16'h5555
`define HSE_REF3           16'h8000
`define HSE_REF4           16'hAAAB
`define HSE_REF5           16'hD555

// sector period counter limit and divider step count
`define HSE_PERIOD_MAX     16'hFFFF
`define HSE_DIV_STEPS      5'h11

`endif

// *** verilog/hse_pkg.sv ***
// types for the hall angle and speed estimator
package hse_pkg;

  typedef enum logic [1:0] {
    HSE_MODE_SINGLE = 2'b00,
    HSE_MODE_AVG6   = 2'b01,
    HSE_MODE_AUTO   = 2'b10
  } hse_mode_type;

  typedef enum logic {
    HSE_DIV_IDLE = 1'b0,
    HSE_DIV_RUN  = 1'b1
  } hse_div_state_type;

endpackage

// *** verilog/hse_div_if.sv ***
// divider request and answer between estimator and divider
`timescale 1ns/1ps
interface hse_div_if;
  logic        start;
  logic [18:0] divisor;
  logic        done;
  logic [15:0] quotient;

  modport master (output start, output divisor, input done, input quotient);
  modport slave  (input start, input divisor, output done, output quotient);
endinterface

// *** verilog/hse_turn_div.sv ***
// serial divider: one full turn divided by a period count
`timescale 1ns/1ps
module hse_turn_div
  import hse_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  // request and answer
  hse_div_if.slave   div
);
`include "hse_consts.svh"

  hse_div_state_type state_q;
  logic [18:0]       divisor_q;
  logic [16:0]       dividend_q;
  logic [19:0]       rem_q;
  logic [16:0]       quo_q;
  logic [4:0]        step_q;
  logic [15:0]       result_q;
  logic              done_q;
  logic [19:0]       rem_shift;
  logic [19:0]       rem_sub;
  logic              fits;

  assign rem_shift = {rem_q[18:0], dividend_q[16]};
  assign rem_sub   = rem_shift - {1'b0, divisor_q};
  assign fits      = (rem_shift >= {1'b0, divisor_q});

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q    <= HSE_DIV_IDLE;
      divisor_q  <= 19'h00000;
      dividend_q <= 17'h00000;
      rem_q      <= 20'h00000;
      quo_q      <= 17'h00000;
      step_q     <= 5'h00;
      result_q   <= 16'h0000;
      done_q     <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        HSE_DIV_IDLE:
        begin
          if (div.start)
          begin
            divisor_q  <= div.divisor;
            dividend_q <= `HSE_TURN;
            rem_q      <= 20'h00000;
            quo_q      <= 17'h00000;
            step_q     <= `HSE_DIV_STEPS;
            state_q    <= HSE_DIV_RUN;
          end
        end
        HSE_DIV_RUN:
        begin
          rem_q      <= fits ? rem_sub : rem_shift;
          quo_q      <= {quo_q[15:0], fits};
          dividend_q <= {dividend_q[15:0], 1'b0};
          step_q     <= step_q - 5'h01;
          if (step_q == 5'h01)
          begin
            // a short early average can push the quotient past 16 bits, so saturate
            result_q <= quo_q[15] ? 16'hFFFF : {quo_q[14:0], fits};
            done_q   <= 1'b1;
            state_q  <= HSE_DIV_IDLE;
          end
        end
        default: state_q <= HSE_DIV_IDLE;
      endcase
    end
  end

  assign div.done     = done_q;
  assign div.quotient = result_q;
endmodule

// *** verilog/hse_estimator.sv ***
// hall sensor sector decode, speed estimate and angle interpolation
`timescale 1ns/1ps
`include "hse_consts.svh"
module hse_estimator
  import hse_pkg::*;
#(
  parameter int unsigned CTRL_CYC = `HSE_CTRL_CYC
)
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // hall inputs
  input  wire logic        I_HALL_INPUT_U,
  input  wire logic        I_HALL_INPUT_V,
  input  wire logic        I_HALL_INPUT_W,
  // configuration
  input  wire logic [1:0]  I_SPEED_MODE,
  input  wire logic [15:0] I_OFFSET,
  // estimates
  output logic      [15:0] O_ANGLE,
  output logic      [2:0]  O_SECTOR,
  output logic             O_DIR_CW,
  output logic      [15:0] O_STEP,
  output logic      [31:0] O_SPEED,
  output logic      [15:0] O_SECTOR_PERIOD,
  output logic             O_TICK,
  output logic             O_CODE_ERR
);

  localparam logic [15:0] TICK_LAST = 16'(CTRL_CYC - 1);
  localparam logic [15:0] CARRIER   = 16'(`HSE_CARRIER_HZ);

  // pattern number 1..6 from code, 0 when invalid
  function automatic logic [2:0] code_to_sector(input logic [2:0] code);
    case (code)
      3'h1:    code_to_sector = 3'h1;
      3'h5:    code_to_sector = 3'h2;
      3'h4:    code_to_sector = 3'h3;
      3'h6:    code_to_sector = 3'h4;
      3'h2:    code_to_sector = 3'h5;
      3'h3:    code_to_sector = 3'h6;
      default: code_to_sector = 3'h0;
    endcase
  endfunction

  hse_div_if div ();

  hse_turn_div hse_turn_div_inst (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .div   (div.slave)
  );

  logic [15:0] tick_cnt_q;
  logic        tick_q;
  logic [2:0]  sector_q;
  logic        dir_cw_q;
  logic [15:0] count_q;
  logic [15:0] period_q [`HSE_SECTORS];
  logic [2:0]  filled_q;
  logic [15:0] step_q;
  logic signed [17:0] int_q;
  logic [15:0] angle_q;
  logic        err_q;
  logic        start_q;
  logic [18:0] divisor_q;
  logic [31:0] speed_q;

  wire         tick_hit = (tick_cnt_q == TICK_LAST);
  wire  [2:0]  code     = (I_HALL_INPUT_W ? `HSE_W_WEIGHT : 3'h0)
                        + (I_HALL_INPUT_V ? `HSE_V_WEIGHT : 3'h0)
                        + (I_HALL_INPUT_U ? `HSE_U_WEIGHT : 3'h0);
  wire  [2:0]  new_sec  = code_to_sector(code);
  wire         invalid  = (new_sec == 3'h0);
  wire         changed  = !invalid && (new_sec != sector_q) && (sector_q != 3'h0);
  wire         first    = !invalid && (sector_q == 3'h0);
  wire  [2:0]  sec_up   = (sector_q == 3'h6) ? 3'h1 : sector_q + 3'h1;
  wire  [2:0]  sec_dn   = (sector_q == 3'h1) ? 3'h6 : sector_q - 3'h1;
  wire         go_cw    = (new_sec == sec_up);
  wire         go_ccw   = (new_sec == sec_dn);
  wire         new_cw   = go_cw ? 1'b1 : (go_ccw ? 1'b0 : dir_cw_q);
  wire         reversal = changed && (new_cw != dir_cw_q);
  wire  [15:0] count_inc = (count_q == `HSE_PERIOD_MAX) ? count_q : count_q + 16'h0001;
  wire         stalled  = (count_q == `HSE_PERIOD_MAX);

  // six period sum for the averaged estimate
  logic [18:0] sum6;
  always_comb
  begin
    sum6 = 19'h00000;
    for (int i = 0; i < `HSE_SECTORS; i++)
      sum6 = sum6 + {3'h0, period_q[i]};
  end

  // auto uses the single estimate until six periods in one direction exist
  wire         use_avg  = (I_SPEED_MODE == HSE_MODE_AVG6)
                       || ((I_SPEED_MODE == HSE_MODE_AUTO) && (filled_q == 3'h6) && !reversal);
  wire  [18:0] single_div = 19'(count_q) * 19'h00006;
  wire  [18:0] avg_div    = sum6 - {3'h0, period_q[`HSE_SECTORS-1]} + {3'h0, count_q};

  // sector reference angle
  wire  [15:0] ref_ang = (sector_q == 3'h2) ? `HSE_REF1 :
                         (sector_q == 3'h3) ? `HSE_REF2 :
                         (sector_q == 3'h4) ? `HSE_REF3 :
                         (sector_q == 3'h5) ? `HSE_REF4 :
                         (sector_q == 3'h6) ? `HSE_REF5 : `HSE_REF0;

  // integrator with clamp
  wire signed [17:0] step_s = $signed({2'b00, step_q});
  wire signed [17:0] int_sum = dir_cw_q ? int_q + step_s : int_q - step_s;
  wire signed [17:0] hi_lim  = $signed(`HSE_HALF_SECTOR);
  wire signed [17:0] lo_lim  = -$signed(`HSE_HALF_SECTOR);
  wire signed [17:0] int_clamp = (int_sum > hi_lim) ? hi_lim :
                                 (int_sum < lo_lim) ? lo_lim : int_sum;
  wire signed [17:0] int_load = new_cw ? lo_lim : hi_lim;

  // sum truncated to 16 bits wraps into one turn
  wire  [15:0] angle_d = ref_ang + int_q[15:0] + I_OFFSET;

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= tick_hit ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      tick_q    <= 1'b0;
      sector_q  <= 3'h0;
      dir_cw_q  <= 1'b1;
      count_q   <= 16'h0000;
      filled_q  <= 3'h0;
      int_q     <= 18'sh00000;
      err_q     <= 1'b0;
      start_q   <= 1'b0;
      divisor_q <= 19'h00006;
    end
    else
    begin
      tick_q  <= tick_hit;
      start_q <= 1'b0;
      if (tick_hit)
      begin
        err_q <= invalid;
        if (first)
        begin
          sector_q <= new_sec;
          count_q  <= 16'h0001;
          int_q    <= 18'sh00000;
        end
        else if (changed)
        begin
          sector_q  <= new_sec;
          dir_cw_q  <= new_cw;
          count_q   <= 16'h0001;
          int_q     <= int_load;
          filled_q  <= reversal ? 3'h1 : ((filled_q == 3'h6) ? filled_q : filled_q + 3'h1);
          start_q   <= 1'b1;
          divisor_q <= use_avg ? avg_div : single_div;
        end
        else
        begin
          count_q <= count_inc;
          int_q   <= int_clamp;
        end
      end
    end
  end

  // period history shift on each edge
  generate
    for (genvar g = 0; g < `HSE_SECTORS; g++)
    begin : g_hist
      always_ff @(posedge I_CLK or posedge I_RST)
      begin
        if (I_RST)
          period_q[g] <= 16'h0000;
        else if (tick_hit && changed)
          period_q[g] <= (g == 0) ? count_q : period_q[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate

  // step per interval and speed in angle counts per second
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      step_q    <= 16'h0000;
      speed_q   <= 32'h00000000;
      angle_q   <= 16'h0000;
    end
    else
    begin
      angle_q <= angle_d;
      if (tick_hit && stalled)
        step_q <= 16'h0000;
      else if (div.done)
        step_q <= div.quotient;
      speed_q <= 32'(step_q) * 32'(CARRIER);
    end
  end

  assign div.start   = start_q;
  assign div.divisor = divisor_q;

  assign O_ANGLE         = angle_q;
  assign O_SECTOR        = sector_q;
  assign O_DIR_CW        = dir_cw_q;
  assign O_STEP          = step_q;
  assign O_SPEED         = speed_q;
  assign O_SECTOR_PERIOD = period_q[0];
  assign O_TICK          = tick_q;
  assign O_CODE_ERR      = err_q;
endmodule

// *** tb/hse_hall_model.sv ***
// three-sensor hall source stepping through the six patterns
`timescale 1ns/1ps
module hse_hall_model
(
  // control from the bench
  input  wire logic       i_clk,
  input  wire logic       i_adv,
  input  wire logic       i_ccw,
  input  wire logic       i_bad,
  input  wire logic [2:0] i_bad_code,
  // sensor levels
  output logic            o_u,
  output logic            o_v,
  output logic            o_w
);
  localparam logic [2:0] CODES [6] = '{3'h1, 3'h5, 3'h4, 3'h6, 3'h2, 3'h3};
  int pos = 0;
  assign {o_u, o_v, o_w} = i_bad ? i_bad_code : CODES[pos];
  // moves on the falling edge, never while the estimator samples
  always @(negedge i_clk)
  begin
    if (i_adv)
      pos <= i_ccw ? (pos + 5) % 6 : (pos + 1) % 6;
  end
endmodule

// *** tb/hse_estimator_assertions.sv ***
// port checks for the hall estimator
`timescale 1ns/1ps
`include "hse_consts.svh"
module hse_estimator_assertions
  import hse_pkg::*;
#(
  parameter int unsigned CTRL_CYC = 20
)
(
  // inputs
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_HALL_INPUT_U,
  input wire logic        I_HALL_INPUT_V,
  input wire logic        I_HALL_INPUT_W,
  input wire logic [1:0]  I_SPEED_MODE,
  input wire logic [15:0] I_OFFSET,
  // outputs
  input wire logic [15:0] O_ANGLE,
  input wire logic [2:0]  O_SECTOR,
  input wire logic        O_DIR_CW,
  input wire logic [15:0] O_STEP,
  input wire logic [31:0] O_SPEED,
  input wire logic [15:0] O_SECTOR_PERIOD,
  input wire logic        O_TICK,
  input wire logic        O_CODE_ERR
);
  localparam logic [2:0]  PAT [8] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h3, 3'h2, 3'h4, 3'h0};
  localparam logic [15:0] REF [7] = '{`HSE_REF0, `HSE_REF0, `HSE_REF1, `HSE_REF2, `HSE_REF3, `HSE_REF4, `HSE_REF5};
  localparam logic [15:0] HALF    = 16'(`HSE_HALF_SECTOR);
  wire logic [2:0]  code_w = {I_HALL_INPUT_U, I_HALL_INPUT_V, I_HALL_INPUT_W};
  logic [15:0]      off_q;
  int               cnt_q;
  wire logic [15:0] diff_w = O_ANGLE - REF[O_SECTOR] - off_q;
  // starts at -1 so the first tick lines up with the later ones
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cnt_q <= -1;
      off_q <= 16'h0000;
    end
    else
    begin
      cnt_q <= O_TICK ? 0 : cnt_q + 1;
      off_q <= I_OFFSET;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_edge;
    O_TICK && !O_CODE_ERR && $past(O_SECTOR) != 3'h0 && O_SECTOR != $past(O_SECTOR);
  endsequence
  property p_single;
    logic [15:0] k;
    (s_edge ##0 I_SPEED_MODE[0] == I_SPEED_MODE[1], k = O_SECTOR_PERIOD) |-> ##24 O_STEP == 16'(32'h10000 / (32'h6 * k));
  endproperty
  AST_TICK: assert property (O_TICK == (cnt_q == CTRL_CYC - 1))
    else $error("tick spacing wrong");
  AST_SECTOR: assert property (O_TICK && PAT[$past(code_w)] != 3'h0 |-> O_SECTOR == PAT[$past(code_w)])
    else $error("sector decode wrong");
  AST_ERR: assert property (O_TICK |-> O_CODE_ERR == (PAT[$past(code_w)] == 3'h0))
    else $error("code error flag wrong");
  AST_HOLD: assert property (O_TICK && O_CODE_ERR |-> $stable(O_SECTOR))
    else $error("sector moved on bad code");
  AST_DIR: assert property (s_edge |-> (O_SECTOR != $past(O_SECTOR) % 3'h6 + 3'h1 || O_DIR_CW) && ($past(O_SECTOR) != O_SECTOR % 3'h6 + 3'h1 || !O_DIR_CW))
    else $error("direction wrong");
  AST_RELOAD: assert property (s_edge |=> O_ANGLE == 16'(REF[$past(O_SECTOR)] + ($past(O_DIR_CW) ? 16'h0 - HALF : HALF) + $past(I_OFFSET)))
    else $error("angle at sector edge wrong");
  AST_CLAMP: assert property (!O_TICK && $stable(O_SECTOR) && O_SECTOR != 3'h0 |-> diff_w <= HALF || diff_w >= 16'h0 - HALF)
    else $error("internal angle out of range");
  AST_STEP: assert property (p_single)
    else $error("single sector step wrong");
  AST_SPEED: assert property (O_SPEED == 32'($past(O_STEP)) * 32'h4E20)
    else $error("speed scale wrong");
endmodule
bind hse_estimator hse_estimator_assertions #(.CTRL_CYC(CTRL_CYC)) hse_estimator_assertions_inst (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_HALL_INPUT_U(I_HALL_INPUT_U), .I_HALL_INPUT_V(I_HALL_INPUT_V),
  .I_HALL_INPUT_W(I_HALL_INPUT_W), .I_SPEED_MODE(I_SPEED_MODE), .I_OFFSET(I_OFFSET), .O_ANGLE(O_ANGLE),
  .O_SECTOR(O_SECTOR), .O_DIR_CW(O_DIR_CW), .O_STEP(O_STEP), .O_SPEED(O_SPEED),
  .O_SECTOR_PERIOD(O_SECTOR_PERIOD), .O_TICK(O_TICK), .O_CODE_ERR(O_CODE_ERR));

// *** tb/hse_estimator_test.sv ***
// self-checking bench for the hall estimator
`timescale 1ns/1ps
module hse_estimator_test;
  import hse_pkg::*;
  localparam int unsigned CYC = 40;
  typedef struct packed { logic [1:0] mode; logic [3:0] k; logic ccw; logic [15:0] step; } hse_row_type;
  hse_row_type rows [4] = '{'{2'b00, 4'h3, 1'b0, 16'h0E38}, '{2'b00, 4'h5, 1'b1, 16'h0888},
                            '{2'b01, 4'h4, 1'b0, 16'h0AAA}, '{2'b10, 4'h2, 1'b0, 16'h1555}};
  logic clk, rst, adv, ccw, bad, u, v, w, dir_cw, tick, err;
  logic [1:0]  mode = 2'b00;
  logic [2:0]  bad_code = 3'h0, sector;
  logic [15:0] offset = 16'h0000, angle, step, period;
  logic [31:0] speed;
  int pos = 0;
  int n_errors = 0;
  int cmp_count = 0;
  hse_estimator #(.CTRL_CYC(CYC)) hse_estimator_inst (.I_CLK(clk), .I_RST(rst), .I_HALL_INPUT_U(u),
    .I_HALL_INPUT_V(v), .I_HALL_INPUT_W(w), .I_SPEED_MODE(mode), .I_OFFSET(offset), .O_ANGLE(angle),
    .O_SECTOR(sector), .O_DIR_CW(dir_cw), .O_STEP(step), .O_SPEED(speed), .O_SECTOR_PERIOD(period),
    .O_TICK(tick), .O_CODE_ERR(err));
  hse_hall_model hse_hall_model_inst (.i_clk(clk), .i_adv(adv), .i_ccw(ccw), .i_bad(bad),
    .i_bad_code(bad_code), .o_u(u), .o_v(v), .o_w(w));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    // tick looked at mid-cycle, where it has settled
    repeat (n) @(negedge clk iff tick === 1'b1);
    @(negedge clk);
  endtask
  // n sector edges, k intervals apart
  task automatic turn(input int n, input int k);
    repeat (n)
    begin
      ticks(k);
      adv <= 1'b1;
      @(negedge clk);
      adv <= 1'b0;
      pos = ccw ? (pos + 5) % 6 : (pos + 1) % 6;
    end
  endtask
  // lets the edge be sampled and the divider finish
  task automatic settle;
    ticks(1);
    repeat (25) @(negedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #300000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    {rst, adv, ccw, bad} = 4'h8;
    repeat (6) @(negedge clk);
    check("dir_rst", dir_cw, 32'h1);
    check("sector_rst", sector, 32'h0);
    rst <= 1'b0;
    ticks(1);
    check("first", sector, 32'h1);
    foreach (rows[i])
    begin
      mode <= rows[i].mode;
      ccw <= rows[i].ccw;
      turn(7, rows[i].k);
      settle();
      check("period", period, rows[i].k);
      check("step", step, rows[i].step);
      check("speed", speed, rows[i].step * 32'h4E20);
      check("dir", dir_cw, !rows[i].ccw);
      check("sector", sector, pos + 1);
    end
    for (int c = 7; c >= 0; c -= 7)
    begin
      bad_code <= 3'(c);
      bad <= 1'b1;
      ticks(2);
      check("err", err, 32'h1);
      check("hold", sector, pos + 1);
    end
    bad <= 1'b0;
    ticks(2);
    check("err_clr", err, 32'h0);
    // mixed periods tell the average from the last period alone
    mode <= 2'b01;
    for (int k = 1; k < 8; k++)
      turn(1, k);
    settle();
    check("avg", step, 16'h097B);
    // auto just after a reversal falls back to the single estimate
    mode <= 2'b10;
    ccw <= 1'b1;
    turn(2, 3);
    settle();
    check("auto", step, 16'h0E38);
    check("auto_dir", dir_cw, 32'h0);
    mode <= 2'b00;
    ccw <= 1'b0;
    offset <= 16'hF000;
    turn(3, 2);
    ticks(4);
    @(negedge clk);
    check("clamp", angle, 16'((pos * 65536 + 3) / 6 + 16'h1555 + 16'hF000));
    // reset in mid-run clears the estimate and relearns the sector
    rst <= 1'b1;
    @(negedge clk);
    check("step_rst", step, 32'h0);
    check("speed_rst", speed, 32'h0);
    rst <= 1'b0;
    ticks(1);
    check("first_again", sector, pos + 1);
    check("err_again", err, 32'h0);
    complete_run();
  end
endmodule
